// file: cles_consts.svh
`ifndef CLES_CONSTS_SVH
`define CLES_CONSTS_SVH

// Register offsets
`define CLES_OFF_GIP      8'h6e
`define CLES_OFF_CHPTR    8'h6f
`define CLES_OFF_CTRL     8'h70
`define CLES_OFF_MLOOP    8'h71
`define CLES_OFF_MCSW     8'h72
`define CLES_OFF_MPLL     8'h73
`define CLES_OFF_PLL      8'had
`define CLES_OFF_LOOP     8'hd7
`define CLES_OFF_CSW      8'hd8
`define CLES_OFF_CLKSTAT  8'hfe

// Field positions
`define CLES_BIT_LOOP_DOWN  0
`define CLES_BIT_LOOP_UP    1
`define CLES_BIT_PLL_CHG    0
`define CLES_BIT_PLL_LOCK   1
`define CLES_BIT_TXSRC_SW   3
`define CLES_BIT_OSCREF_SW  4
`define CLES_BIT_AUX_LOST   3
`define CLES_BIT_TX_LOST    4
`define CLES_BIT_GIP_PLL    2
`define CLES_BIT_GIP_LOOP   6
`define CLES_BIT_GIP_CSW    7
`define CLES_BIT_CH8_PTR    7
`define CLES_BIT_VIS        0
`define CLES_BIT_LILS_EN    1
`define CLES_BIT_AUTO_EN    2
`define CLES_BIT_COMPAT     3
`define CLES_BIT_REF_MODE   4

// Reset values
`define CLES_CTRL_RST   8'h00
`define CLES_MASK_RST   8'hff
`define CLES_STAT_RST   8'h00

`endif

// file: cles_event_status.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cles_consts.svh"
module cles_event_status #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [7:0]        regWrData,
	input  wire logic              regWrEn,
	input  wire logic              regRdEn,
	output logic      [7:0]        regRdData_r,
	// Loop code detectors, same clock
	input  wire logic              loopUpDet,
	input  wire logic              loopDownDet,
	// Asynchronous clock monitors
	input  wire logic              pllLockPin,
	input  wire logic              txClkLostPin,
	input  wire logic              auxClkLostPin,
	// Status and control outputs
	output logic                   intReq_r,
	output logic                   lineLoopOn_r,
	output logic                   xclkFromOsc_r,
	output logic                   oscRefAux_r
);
	initial begin
		if (ADDR_W < 8) $error("cles_event_status: ADDR_W must be at least 8");
	end

	// Two-stage synchronisers for the monitor levels
	logic [2:0] syncA_r;
	logic [2:0] syncB_r;
	logic       lockSync;
	logic       txLost;
	logic       auxLost;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			syncA_r <= 3'h0;
			syncB_r <= 3'h0;
		end else begin
			syncA_r <= {auxClkLostPin, txClkLostPin, pllLockPin};
			syncB_r <= syncA_r;
		end
	end
	assign lockSync = syncB_r[0];
	assign txLost   = syncB_r[1];
	assign auxLost  = syncB_r[2];

	// Control and mask registers
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] mLoop_r;
	logic [7:0] mLoop_nxt;
	logic [7:0] mCsw_r;
	logic [7:0] mCsw_nxt;
	logic [7:0] mPll_r;
	logic [7:0] mPll_nxt;
	logic       visEn;
	logic       lilsEn;
	logic       autoEn;
	logic       compat;
	logic       refMode;

	assign visEn   = ctrl_r[`CLES_BIT_VIS];
	assign lilsEn  = ctrl_r[`CLES_BIT_LILS_EN];
	assign autoEn  = ctrl_r[`CLES_BIT_AUTO_EN];
	assign compat  = ctrl_r[`CLES_BIT_COMPAT];
	assign refMode = ctrl_r[`CLES_BIT_REF_MODE];

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction : hit

	logic rdPll;
	logic rdLoop;
	logic rdCsw;
	logic rdChPtr;
	logic rdClkStat;
	assign rdPll     = regRdEn && hit(regAddr, `CLES_OFF_PLL);
	assign rdLoop    = regRdEn && hit(regAddr, `CLES_OFF_LOOP);
	assign rdCsw     = regRdEn && hit(regAddr, `CLES_OFF_CSW);
	assign rdChPtr   = regRdEn && hit(regAddr, `CLES_OFF_CHPTR);
	assign rdClkStat = regRdEn && hit(regAddr, `CLES_OFF_CLKSTAT);

	// Event flag banks
	logic [1:0] loopFlags;
	logic [1:0] cswFlags;
	logic [1:0] loopMask;
	logic [1:0] cswMask;
	logic [1:0] cswSet;

	assign loopMask = {mLoop_r[`CLES_BIT_LOOP_UP], mLoop_r[`CLES_BIT_LOOP_DOWN]};
	assign cswMask  = {mCsw_r[`CLES_BIT_OSCREF_SW], mCsw_r[`CLES_BIT_TXSRC_SW]};

	cles_rc_flags #(.WIDTH(2)) u_loopFlags (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.evtSet   ({loopUpDet, loopDownDet}),
		.evtMask  (loopMask),
		.visEn    (visEn),
		.holdZero (1'b0),
		.rdClr    (rdLoop),
		.flags_r  (loopFlags)
	);

	cles_rc_flags #(.WIDTH(2)) u_cswFlags (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.evtSet   (cswSet),
		.evtMask  (cswMask),
		.visEn    (visEn),
		.holdZero (!autoEn),
		.rdClr    (rdCsw),
		.flags_r  (cswFlags)
	);

	// Clock path selectors and PLL change tracking
	cles_pkg::cles_src_t xclkSel_r;
	cles_pkg::cles_src_t xclkSel_nxt;
	cles_pkg::cles_src_t oscRef_r;
	cles_pkg::cles_src_t oscRef_nxt;
	logic       lockSnap_r;
	logic       lockSnap_nxt;
	logic       pllChg_r;
	logic       pllChg_nxt;
	logic       lineLoop_nxt;
	logic       loopPend;
	logic       cswPend;
	logic       pllPend;
	logic       anyPend;
	logic [7:0] rdData_nxt;

	// One-hot codes: the alternative-path bit is itself the state flop
	assign xclkFromOsc_r = xclkSel_r[1];
	assign oscRefAux_r   = oscRef_r[1];

	// Only unmasked flags count; visible-but-masked ones stay local
	assign loopPend = |(loopFlags & ~loopMask);
	assign cswPend  = |(cswFlags & ~cswMask);
	assign pllPend  = pllChg_r & ~mPll_r[`CLES_BIT_PLL_CHG];
	assign anyPend  = loopPend | cswPend | pllPend;

	always_comb begin
		ctrl_nxt  = ctrl_r;
		mLoop_nxt = mLoop_r;
		mCsw_nxt  = mCsw_r;
		mPll_nxt  = mPll_r;
		if (regWrEn) begin
			if (hit(regAddr, `CLES_OFF_CTRL))
				ctrl_nxt = regWrData;
			if (hit(regAddr, `CLES_OFF_MLOOP))
				mLoop_nxt = regWrData;
			if (hit(regAddr, `CLES_OFF_MCSW))
				mCsw_nxt = regWrData;
			if (hit(regAddr, `CLES_OFF_MPLL))
				mPll_nxt = regWrData;
		end

		// Line loop follows the codes only while in-band switching is allowed
		lineLoop_nxt = lineLoopOn_r;
		if (lilsEn && loopUpDet)
			lineLoop_nxt = 1'b1;
		else if (lilsEn && loopDownDet)
			lineLoop_nxt = 1'b0;

		// Reference mode: output always from oscillator, its reference swaps on input loss.
		// Source mode: oscillator on auxiliary clock, output source swaps on input loss.
		xclkSel_nxt = cles_pkg::SRC_TXIN;
		oscRef_nxt  = cles_pkg::SRC_TXIN;
		if (refMode) begin
			xclkSel_nxt = cles_pkg::SRC_ALT;
			if (autoEn && txLost)
				oscRef_nxt = cles_pkg::SRC_ALT;
		end else begin
			oscRef_nxt = cles_pkg::SRC_ALT;
			if (autoEn && txLost)
				xclkSel_nxt = cles_pkg::SRC_ALT;
		end
		// A change of mode bits alone can also raise a switch flag when it moves the selector
		cswSet[0] = autoEn && !refMode && (xclkSel_nxt != xclkSel_r);
		cswSet[1] = autoEn && refMode && (oscRef_nxt != oscRef_r);

		// Read clears the change bit and re-arms against the lock level seen now
		lockSnap_nxt = rdPll ? lockSync : lockSnap_r;
		pllChg_nxt   = rdPll ? 1'b0 : (pllChg_r | (lockSync != lockSnap_r));

		rdData_nxt = 8'h00;
		if (regRdEn) begin
			if (hit(regAddr, `CLES_OFF_PLL)) begin
				rdData_nxt[`CLES_BIT_PLL_LOCK] = lockSync;
				rdData_nxt[`CLES_BIT_PLL_CHG]  = pllChg_r;
			end
			if (hit(regAddr, `CLES_OFF_LOOP))
				rdData_nxt[1:0] = loopFlags;
			if (hit(regAddr, `CLES_OFF_CSW)) begin
				rdData_nxt[`CLES_BIT_TXSRC_SW]  = cswFlags[0];
				rdData_nxt[`CLES_BIT_OSCREF_SW] = cswFlags[1];
			end
			if (hit(regAddr, `CLES_OFF_GIP)) begin
				rdData_nxt[`CLES_BIT_GIP_LOOP] = loopPend;
				rdData_nxt[`CLES_BIT_GIP_CSW]  = cswPend;
				rdData_nxt[`CLES_BIT_GIP_PLL]  = pllPend;
			end
			if (hit(regAddr, `CLES_OFF_CHPTR))
				rdData_nxt[`CLES_BIT_CH8_PTR] = compat ? lockSync : anyPend;
			if (hit(regAddr, `CLES_OFF_CLKSTAT)) begin
				rdData_nxt[`CLES_BIT_TX_LOST]  = txLost;
				rdData_nxt[`CLES_BIT_AUX_LOST] = auxLost;
			end
			if (hit(regAddr, `CLES_OFF_CTRL))
				rdData_nxt = ctrl_r;
			if (hit(regAddr, `CLES_OFF_MLOOP))
				rdData_nxt = mLoop_r;
			if (hit(regAddr, `CLES_OFF_MCSW))
				rdData_nxt = mCsw_r;
			if (hit(regAddr, `CLES_OFF_MPLL))
				rdData_nxt = mPll_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ctrl_r       <= `CLES_CTRL_RST;
			mLoop_r      <= `CLES_MASK_RST;
			mCsw_r       <= `CLES_MASK_RST;
			mPll_r       <= `CLES_MASK_RST;
			lineLoopOn_r <= 1'b0;
			xclkSel_r    <= cles_pkg::SRC_TXIN;
			oscRef_r     <= cles_pkg::SRC_ALT;
			lockSnap_r   <= 1'b0;
			pllChg_r     <= 1'b0;
			intReq_r     <= 1'b0;
			regRdData_r  <= `CLES_STAT_RST;
		end else begin
			ctrl_r       <= ctrl_nxt;
			mLoop_r      <= mLoop_nxt;
			mCsw_r       <= mCsw_nxt;
			mPll_r       <= mPll_nxt;
			lineLoopOn_r <= lineLoop_nxt;
			xclkSel_r    <= xclkSel_nxt;
			oscRef_r     <= oscRef_nxt;
			lockSnap_r   <= lockSnap_nxt;
			pllChg_r     <= pllChg_nxt;
			intReq_r     <= anyPend;
			regRdData_r  <= rdData_nxt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	loop_up_flag_a: assert property (loopUpDet && (!loopMask[1] || visEn) |=> loopFlags[1])
		else $error("loop-up event not recorded");
	loop_on_a: assert property (lilsEn && loopUpDet |=> lineLoopOn_r)
		else $error("line loop not switched on");
	loop_off_a: assert property (lilsEn && loopDownDet && !loopUpDet |=> !lineLoopOn_r)
		else $error("line loop not switched off");
	loop_down_flag_a: assert property (loopDownDet && (!loopMask[0] || visEn) |=> loopFlags[0])
		else $error("loop-down event not recorded");
	lock_read_a: assert property (rdPll |=> regRdData_r[`CLES_BIT_PLL_LOCK] == $past(lockSync))
		else $error("lock state misreported");
	lock_change_a: assert property (!rdPll && lockSync != lockSnap_r |=> pllChg_r ##1 pllChg_r || $past(rdPll))
		else $error("lock change not flagged");
	lock_clear_a: assert property (rdPll |=> !pllChg_r)
		else $error("lock change not cleared by read");
	csw_clear_a: assert property (rdCsw && cswSet == 2'h0 |=> cswFlags == 2'h0)
		else $error("switch flags survive read");
	csw_visible_a: assert property (autoEn && cswSet[0] && cswMask[0] && visEn |=> cswFlags[0])
		else $error("masked visible event dropped");
	int_masked_a: assert property (!anyPend |=> !intReq_r)
		else $error("masked flag drove interrupt");
	osc_ref_a: assert property (autoEn && refMode && txLost && !oscRefAux_r && (!cswMask[1] || visEn) |=> oscRefAux_r && cswFlags[1])
		else $error("reference switch not flagged");
	src_lost_a: assert property (autoEn && !refMode && txLost && !xclkFromOsc_r && (!cswMask[0] || visEn) |=> xclkFromOsc_r && cswFlags[0])
		else $error("source loss switch not flagged");
	src_back_a: assert property (autoEn && !refMode && !txLost && xclkFromOsc_r && (!cswMask[0] || visEn) |=> !xclkFromOsc_r && cswFlags[0])
		else $error("source return not flagged");
	auto_off_a: assert property (!autoEn |=> cswFlags == 2'h0)
		else $error("switch flags set while auto off");
	clk_stat_a: assert property (rdClkStat |=> regRdData_r[`CLES_BIT_TX_LOST] == $past(txLost))
		else $error("input clock loss misreported");
	ch_ptr_a: assert property (rdChPtr && !compat |=> regRdData_r[`CLES_BIT_CH8_PTR] == $past(anyPend))
		else $error("channel pointer wrong");
	int_level_a: assert property (anyPend ##1 anyPend |-> intReq_r)
		else $error("interrupt missing while pending");

	sequence src_lost_pair;
		autoEn && !refMode && !xclkFromOsc_r ##1 xclkFromOsc_r ##[1:100] !xclkFromOsc_r;
	endsequence
	loop_switch_c: cover property (lilsEn && loopUpDet ##[1:50] lilsEn && loopDownDet);
	src_round_c: cover property (src_lost_pair);
	masked_vis_c: cover property (visEn && cswFlags != 2'h0 && !cswPend);
endmodule : cles_event_status
`default_nettype wire

// file: cles_event_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cles_consts.svh"
module cles_event_status_tb;
	logic       ref_clk;
	logic       rst_b;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrEn;
	logic       regRdEn;
	logic [7:0] regRdData_r;
	logic       loopUpDet;
	logic       loopDownDet;
	logic       pllLockPin;
	logic       txClkLostPin;
	logic       auxClkLostPin;
	logic       intReq_r;
	logic       lineLoopOn_r;
	logic       xclkFromOsc_r;
	logic       oscRefAux_r;
	logic       rdSeen;
	logic       loopExp;
	logic       en;
	logic       up;
	logic       dn;
	logic [7:0] expQ[$];
	logic [7:0] mskQ[$];
	int         errTotal;
	int         checksDone;
	int         seed;

	cles_event_status #(.ADDR_W(8)) dut_u (
		.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
		.loopUpDet(loopUpDet), .loopDownDet(loopDownDet), .pllLockPin(pllLockPin),
		.txClkLostPin(txClkLostPin), .auxClkLostPin(auxClkLostPin), .intReq_r(intReq_r),
		.lineLoopOn_r(lineLoopOn_r), .xclkFromOsc_r(xclkFromOsc_r), .oscRefAux_r(oscRefAux_r)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish;
		$display("Checks %0d, errors %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
		checksDone++;
		if (((g ^ e) & m) !== 8'h00) begin
			errTotal++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp8

	task automatic cmp1(input string nm, input logic e, input logic g);
		checksDone++;
		if (g !== e) begin
			errTotal++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp1

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr   <= a;
		regWrData <= d;
		regWrEn   <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
	endtask : wr

	// Mask bits at 0 are not compared; an all-zero mask only performs the clearing read
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge ref_clk);
		regRdEn <= 1'b0;
	endtask : rd

	task automatic pulse(input logic u, input logic d);
		@(posedge ref_clk);
		loopUpDet   <= u;
		loopDownDet <= d;
		@(posedge ref_clk);
		loopUpDet   <= 1'b0;
		loopDownDet <= 1'b0;
	endtask : pulse

	// Covers the two synchroniser stages plus flag and interrupt registers
	// Ends mid-cycle so that levels are read after the edge has settled them
	task automatic settle;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle

	task automatic setTx(input logic v);
		@(posedge ref_clk);
		txClkLostPin <= v;
		settle();
	endtask : setTx

	always @(posedge ref_clk) begin
		rdSeen <= regRdEn;
	end

	// Read data stand only in the cycle after the strobe, so they are taken mid-cycle
	always @(negedge ref_clk) begin
		if (rdSeen === 1'b1 && expQ.size() > 0) begin
			cmp8("regRdData_r", expQ[0], regRdData_r, mskQ[0]);
			void'(expQ.pop_front());
			void'(mskQ.pop_front());
		end
	end

	initial begin
		#(40 * 20000);
		errTotal++;
		$display("ERROR watchdog expected done seen timeout");
		tally_and_finish();
	end

	initial begin
		seed = 40225;
		errTotal = 0;
		checksDone = 0;
		rst_b = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		loopUpDet = 1'b0;
		loopDownDet = 1'b0;
		pllLockPin = 1'b0;
		txClkLostPin = 1'b0;
		auxClkLostPin = 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		settle();
		cmp1("intReq_r", 1'b0, intReq_r);
		cmp1("oscRefAux_r", 1'b1, oscRefAux_r);
		rd(`CLES_OFF_CTRL, `CLES_CTRL_RST, 8'hff);
		rd(`CLES_OFF_MCSW, `CLES_MASK_RST, 8'hff);
		rd(`CLES_OFF_CSW, `CLES_STAT_RST, 8'hff);
		rd(`CLES_OFF_PLL, 8'h00, 8'hff);
		rd(8'h10, 8'h00, 8'hff);
		wr(`CLES_OFF_CSW, 8'hff);
		rd(`CLES_OFF_CSW, 8'h00, 8'hff);
		wr(`CLES_OFF_CTRL, 8'h02);
		wr(`CLES_OFF_MLOOP, 8'h00);
		pulse(1'b1, 1'b0);
		settle();
		cmp1("lineLoopOn_r", 1'b1, lineLoopOn_r);
		cmp1("intReq_r", 1'b1, intReq_r);
		rd(`CLES_OFF_GIP, 8'h40, 8'hff);
		rd(`CLES_OFF_CHPTR, 8'h80, 8'h80);
		rd(`CLES_OFF_LOOP, 8'h02, 8'hff);
		rd(`CLES_OFF_LOOP, 8'h00, 8'hff);
		settle();
		cmp1("intReq_r", 1'b0, intReq_r);
		pulse(1'b0, 1'b1);
		settle();
		cmp1("lineLoopOn_r", 1'b0, lineLoopOn_r);
		rd(`CLES_OFF_LOOP, 8'h01, 8'hff);
		@(posedge ref_clk);
		pllLockPin <= 1'b1;
		settle();
		rd(`CLES_OFF_PLL, 8'h03, 8'hff);
		rd(`CLES_OFF_PLL, 8'h02, 8'hff);
		rd(`CLES_OFF_PLL, 8'h02, 8'hff);
		wr(`CLES_OFF_CTRL, 8'h08);
		rd(`CLES_OFF_CHPTR, 8'h80, 8'h80);
		wr(`CLES_OFF_CTRL, 8'h00);
		wr(`CLES_OFF_MPLL, 8'h00);
		@(posedge ref_clk);
		pllLockPin <= 1'b0;
		settle();
		cmp1("intReq_r", 1'b1, intReq_r);
		rd(`CLES_OFF_GIP, 8'h04, 8'hff);
		rd(`CLES_OFF_CHPTR, 8'h80, 8'h80);
		rd(`CLES_OFF_PLL, 8'h01, 8'hff);
		rd(`CLES_OFF_PLL, 8'h00, 8'hff);
		settle();
		cmp1("intReq_r", 1'b0, intReq_r);
		wr(`CLES_OFF_CTRL, 8'h04);
		setTx(1'b1);
		cmp1("xclkFromOsc_r", 1'b1, xclkFromOsc_r);
		rd(`CLES_OFF_CSW, 8'h00, 8'hff);
		rd(`CLES_OFF_CLKSTAT, 8'h10, 8'h18);
		wr(`CLES_OFF_CTRL, 8'h05);
		setTx(1'b0);
		cmp1("xclkFromOsc_r", 1'b0, xclkFromOsc_r);
		cmp1("intReq_r", 1'b0, intReq_r);
		rd(`CLES_OFF_GIP, 8'h00, 8'hff);
		rd(`CLES_OFF_CSW, 8'h08, 8'hff);
		rd(`CLES_OFF_CSW, 8'h00, 8'hff);
		wr(`CLES_OFF_MCSW, 8'h00);
		setTx(1'b1);
		cmp1("intReq_r", 1'b1, intReq_r);
		rd(`CLES_OFF_GIP, 8'h80, 8'hff);
		rd(`CLES_OFF_CSW, 8'h08, 8'hff);
		// Mode change may move the selector itself, so that flag is discarded
		wr(`CLES_OFF_CTRL, 8'h15);
		settle();
		rd(`CLES_OFF_CSW, 8'h00, 8'h00);
		cmp1("oscRefAux_r", 1'b1, oscRefAux_r);
		setTx(1'b0);
		cmp1("oscRefAux_r", 1'b0, oscRefAux_r);
		cmp1("xclkFromOsc_r", 1'b1, xclkFromOsc_r);
		rd(`CLES_OFF_CSW, 8'h10, 8'hff);
		wr(`CLES_OFF_CTRL, 8'h11);
		settle();
		rd(`CLES_OFF_CSW, 8'h00, 8'h00);
		setTx(1'b1);
		@(posedge ref_clk);
		auxClkLostPin <= 1'b1;
		settle();
		rd(`CLES_OFF_CSW, 8'h00, 8'hff);
		rd(`CLES_OFF_CLKSTAT, 8'h18, 8'h18);
		setTx(1'b0);
		rd(`CLES_OFF_CSW, 8'h00, 8'hff);
		auxClkLostPin <= 1'b0;
		loopExp = 1'b0;
		for (int i = 0; i < 24; i++) begin
			en = 1'($random(seed));
			up = 1'($random(seed));
			dn = 1'($random(seed));
			wr(`CLES_OFF_CTRL, {6'h00, en, 1'b0});
			pulse(up, dn);
			settle();
			if (en && up) begin
				loopExp = 1'b1;
			end else if (en && dn) begin
				loopExp = 1'b0;
			end
			cmp1("lineLoopOn_r", loopExp, lineLoopOn_r);
			rd(`CLES_OFF_LOOP, {6'h00, up, dn}, 8'hff);
		end
		settle();
		tally_and_finish();
	end
endmodule : cles_event_status_tb
`default_nettype wire

// file: cles_pkg.sv
`default_nettype none
package cles_pkg;
	// Selector of a clock path: the transmit clock input or its alternative
	typedef enum logic [1:0] {
		SRC_TXIN = 2'b01,
		SRC_ALT  = 2'b10
	} cles_src_t;
endpackage : cles_pkg
`default_nettype wire

// file: cles_rc_flags.sv
`timescale 1ns/1ps
`default_nettype none
module cles_rc_flags #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// Events and gating
	input  wire logic [WIDTH-1:0] evtSet,
	input  wire logic [WIDTH-1:0] evtMask,
	input  wire logic             visEn,
	input  wire logic             holdZero,
	input  wire logic             rdClr,
	// Sticky flags
	output logic      [WIDTH-1:0] flags_r
);
	logic [WIDTH-1:0] flags_nxt;
	logic [WIDTH-1:0] liveEvt;

	// Events that must never be dropped, whatever the visibility setting
	assign liveEvt = evtSet & ~evtMask;

	initial begin
		if (WIDTH < 1 || WIDTH > 8) $error("cles_rc_flags: WIDTH must be 1..8");
	end

	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			// A masked event is only kept when masked visibility is on
			always_comb begin
				if (holdZero)
					flags_nxt[i] = 1'b0;
				else
					flags_nxt[i] = (flags_r[i] & ~rdClr) | (evtSet[i] & (~evtMask[i] | visEn));
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			flags_r <= '0;
		else
			flags_r <= flags_nxt;
	end

	flag_set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!holdZero && liveEvt != '0) |=> (flags_r & $past(liveEvt)) == $past(liveEvt))
		else $error("unmasked event lost");
endmodule : cles_rc_flags
`default_nettype wire
